// ---- tb/rph_host_model.sv ----
// host controller model issuing decoded register transactions
module rph_host_model (
    input wire logic ref_clk_i,
    output rph_pkg::rph_req_t req_o,
    input wire rph_pkg::rph_rsp_t rsp_i
);
    import rph_pkg::*;
    initial req_o = '0;
    // one transfer, answer taken in the cycle where it stands
    task automatic xfer(input logic rem, input logic [6:0] dev, input logic wr,
        input logic [7:0] off, input logic [7:0] wd, output logic ack, output logic [7:0] rd);
        @(posedge ref_clk_i);
        #1;
        req_o = {1'b1, rem, wr, dev, off, wd};
        @(posedge ref_clk_i);
        #1;
        // released fields flip so a stale value never looks live
        req_o = {1'b0, ~req_o[24:0]};
        // the answer stands for one cycle after the second edge
        @(posedge ref_clk_i);
        #1;
        ack = rsp_i.done ? rsp_i.ack : 1'bx;
        rd = rsp_i.done ? rsp_i.rdata : 8'hxx;
    endtask
endmodule

// ---- tb/rph_rx_port_ctrl_bench.sv ----
// self-checking bench for the receive port paging control
module rph_rx_port_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rph_pkg::*;
    localparam int LOSS = 50;
    localparam logic [6:0] MA = 7'h30;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] lock_i = 4'h0;
    logic refin = 1'b0;
    logic ref_run = 1'b1;
    rph_req_t req;
    rph_rsp_t rsp;
    logic [3:0] port_on, fwd_on, eq_restart, eq_locked, pen;
    logic ref_int, ref_lost, ack, seen;
    logic [7:0] seed = 8'h0a;
    logic [7:0] rd, v, eqv [4];
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;

    rph_rx_port_ctrl #(.MAIN_ADDR(MA), .LOSS_CYC(LOSS)) i_rph_rx_port_ctrl (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req), .lock_i(lock_i),
        .reference_clock_input_i(refin), .rsp_o(rsp), .port_on_o(port_on),
        .fwd_on_o(fwd_on), .eq_restart_o(eq_restart), .eq_locked_o(eq_locked),
        .ref_internal_o(ref_int), .ref_lost_o(ref_lost));
    rph_host_model i_rph_host_model (.ref_clk_i(ref_clk_i), .req_o(req), .rsp_i(rsp));

    always #5 ref_clk_i = ~ref_clk_i;
    // reference at a quarter of the core rate, halted only by the loss scenario
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (ref_run && cycles[0]) refin <= #1 ~refin;
        if (cycles == 5000) begin
            errors++;
            end_sim();
        end
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [3:0] exp_fwd(input logic [3:0] f, input logic [3:0] en);
        return f & en;
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask
    task automatic rw(input logic [6:0] dev, input logic wr, input logic [7:0] off,
        input logic [7:0] wd, input logic [7:0] exp);
        i_rph_host_model.xfer(1'b0, dev, wr, off, wd, ack, rd);
        chk("ack", 8'h01, {7'h0, ack});
        chk("rdata", exp, rd);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        // ----------------------------------------
        // reset state
        // ----------------------------------------
        chk("backup osc", 8'h01, {7'h0, ref_int});
        rw(MA, 0, OFF_PORT_EN, 0, 8'h0f);
        rw(MA, 0, OFF_FWD, 0, 8'h00);
        rw(MA, 0, OFF_PAGE, 0, 8'h00);
        for (int p = 0; p < 4; p++) rw(MA, 0, 8'(OFF_DIR_FIRST + p), 0, 8'h00);
        // link-side write must not switch ports off
        i_rph_host_model.xfer(1'b1, MA, 1'b1, OFF_PORT_EN, 8'h00, ack, rd);
        chk("remote write", 8'h0f, {4'h0, port_on});
        // ----------------------------------------
        // enables and forwarding random, enables also at both extremes
        // ----------------------------------------
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            pen = (i == 0) ? 4'h0 : (i == 5) ? 4'hf : seed[3:0];
            rw(MA, 1, OFF_PORT_EN, {4'h0, pen}, {4'h0, pen});
            rw(MA, 1, OFF_FWD, {4'h0, seed[7:4]}, {4'h0, seed[7:4]});
            chk("port on", {4'h0, pen}, {4'h0, port_on});
            chk("fwd on", {4'h0, exp_fwd(seed[7:4], pen)}, {4'h0, fwd_on});
        end
        // ----------------------------------------
        // paging, then direct addresses over a stale page
        // ----------------------------------------
        for (int p = 0; p < 8; p++) begin
            seed = lfsr(seed);
            if (p < 4) eqv[p] = seed;
            rw(MA, 1, OFF_PAGE, 8'(p % 4), 8'(p % 4));
            rw(MA, p < 4, OFF_EQ_FIRST, seed, eqv[p % 4]);
        end
        for (int p = 0; p < 4; p++) begin
            v = {7'(7'h40 + p), 1'b1};
            rw(MA, 1, 8'(OFF_DIR_FIRST + p), v, v);
            rw(v[7:1], 0, OFF_EQ_FIRST, 0, eqv[p]);
            rw(v[7:1], 0, OFF_PAGE, 0, 8'(p));
            rw(v[7:1], 0, OFF_PORT_EN, 0, 8'h0f);
        end
        i_rph_host_model.xfer(1'b0, 7'h7f, 1'b0, OFF_PORT_EN, 8'h00, ack, rd);
        chk("nack", 8'h00, {7'h0, ack});
        // ----------------------------------------
        // lock loss on port 1
        // ----------------------------------------
        lock_i = 4'hf;
        repeat (8) @(posedge ref_clk_i);
        #1;
        chk("locked", 8'h0f, {4'h0, eq_locked});
        rw(MA, 0, OFF_EQ_STAT, 0, 8'h01);
        lock_i = 4'hd;
        seen = 1'b0;
        repeat (4) begin
            @(posedge ref_clk_i);
            #1;
            seen = seen | eq_restart[1];
        end
        chk("restart", 8'h01, {7'h0, seen});
        lock_i = 4'hf;
        // ----------------------------------------
        // reference stall
        // ----------------------------------------
        chk("ref in use", 8'h00, {7'h0, ref_int});
        ref_run = 1'b0;
        repeat (LOSS + 10) @(posedge ref_clk_i);
        #1;
        chk("ref lost", 8'h01, {7'h0, ref_lost});
        chk("fallback", 8'h01, {7'h0, ref_int});
        end_sim();
    end
endmodule

// ---- tb/rph_rx_port_ctrl_checker.sv ----
// assertions on the receive port paging control ports
module rph_rx_port_ctrl_checker #(
    parameter int LOSS_CYC = 2000
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire rph_pkg::rph_req_t req_i,
    input wire logic [3:0] lock_i,
    input wire logic reference_clock_input_i,
    input wire rph_pkg::rph_rsp_t rsp_o,
    input wire logic [3:0] port_on_o,
    input wire logic [3:0] fwd_on_o,
    input wire logic [3:0] eq_restart_o,
    input wire logic [3:0] eq_locked_o,
    input wire logic ref_internal_o,
    input wire logic ref_lost_o
);
    import rph_pkg::*;
    // ----------------------------------------
    // cycles since the reference last changed
    // ----------------------------------------
    logic ref_prev_r;
    int stall_r;
    always_ff @(posedge ref_clk_i) begin
        ref_prev_r <= reference_clock_input_i;
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || reference_clock_input_i != ref_prev_r) begin
            stall_r <= 0;
        end else begin
            stall_r <= stall_r + 1;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    req_answer_a: assert property (req_i.valid |-> ##2 rsp_o.done)
        else $error("late answer");
    nack_zero_a: assert property (rsp_o.done && !rsp_o.ack |-> rsp_o.rdata == 8'h00)
        else $error("nack with data");
    fwd_gated_a: assert property ((fwd_on_o & ~port_on_o) == 4'h0)
        else $error("forwarding on a disabled port");
    fwd_reset_a: assert property ($fell(rst_i) |-> fwd_on_o == 4'h0)
        else $error("forwarding on after reset");
    ports_up_a: assert property ($fell(rst_i) |=> port_on_o == 4'hf)
        else $error("ports not enabled after reset");
    osc_start_a: assert property ($fell(rst_i) |-> ref_internal_o)
        else $error("backup oscillator not used");
    restart_cause_a: assert property (eq_restart_o != 4'h0 |->
        (eq_restart_o & $past(lock_i)) == 4'h0)
        else $error("restart without lock loss");
    loss_late_a: assert property ($rose(ref_lost_o) |-> stall_r >= LOSS_CYC - 3)
        else $error("loss flagged too early");
    loss_flag_a: assert property (stall_r == LOSS_CYC + 6 |-> ref_lost_o)
        else $error("loss not flagged");
endmodule

bind rph_rx_port_ctrl rph_rx_port_ctrl_checker #(.LOSS_CYC(LOSS_CYC)) i_rph_rx_port_ctrl_checker (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i), .lock_i(lock_i),
    .reference_clock_input_i(reference_clock_input_i), .rsp_o(rsp_o),
    .port_on_o(port_on_o), .fwd_on_o(fwd_on_o), .eq_restart_o(eq_restart_o),
    .eq_locked_o(eq_locked_o), .ref_internal_o(ref_internal_o), .ref_lost_o(ref_lost_o));

// ---- verilog/rph_pkg.sv ----
// shared constants and types for the receive port paging block
// How it works
// - four receive inputs run at once, each with its own port logic.
// - register 0x0c holds one enable bit per receive port.
// - port enable writes from the remote link side are ignored.
// - page select register 0x4c picks which port's private registers are reached.
// - each port's own access path sees page select pointing at that port.
// - registers 0xf8-0xfb hold per-port 7-bit target addresses for direct access.
// - direct port addresses also reach the shared registers except page select, whose writes they ignore.
// - forwarding is off after reset; per-port bits in 0x20 turn it on.
// - no reference clock transition for over 20 us is flagged as loss.
// - start-up uses the internal 25 MHz backup oscillator as reference.
// - on lock loss the equalizer resets and reruns lock acquisition.
// - equalizer configuration and status sit at 0xd2 to 0xd5 per port.
package rph_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NUM_PORTS = 4;
    localparam int PW = 2;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_PORT_EN = 8'h0c;
    localparam logic [7:0] OFF_FWD = 8'h20;
    localparam logic [7:0] OFF_PAGE = 8'h4c;
    localparam logic [7:0] OFF_EQ_FIRST = 8'hd2;
    localparam logic [7:0] OFF_EQ_STAT = 8'hd5;
    localparam logic [7:0] OFF_DIR_FIRST = 8'hf8;
    localparam logic [7:0] OFF_DIR_LAST = 8'hfb;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [3:0] RST_PORT_EN = 4'hf;
    localparam logic [3:0] RST_FWD = 4'h0;
    localparam logic [1:0] RST_PAGE = 2'h0;
    localparam logic [7:0] RST_DIR = 8'h00;
    // ----------------------------------------
    // reference clock timing (core clock 100 MHz)
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int REF_LOSS_NS = 20000;
    localparam int REF_LOSS_CYC = REF_LOSS_NS / CLK_PERIOD_NS;
    localparam int REF_GOOD_EDGES = 16;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic remote;
        logic wr;
        logic [6:0] dev_addr;
        logic [7:0] offset;
        logic [7:0] wdata;
    } rph_req_t;

    typedef struct packed {
        logic done;
        logic ack;
        logic [7:0] rdata;
    } rph_rsp_t;

    typedef enum logic [1:0] {EQ_ACQUIRE, EQ_LOCKED, EQ_RESET} rph_eq_state_t;
endpackage

// ---- verilog/rph_port_mem.sv ----
// small per-port register memory with registered read data
module rph_port_mem #(
    parameter int DW = 8,
    parameter int AW = 4
) (
    input wire logic ref_clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_r [2**AW];

    // ----------------------------------------
    // storage; contents are undefined until software writes them
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        rdata_o <= mem_r[raddr_i];
    end
endmodule

// ---- verilog/rph_rx_port_ctrl.sv ----
// receive port enable, paging, direct addressing, forwarding, reference_clock_input and equalizer control
module rph_rx_port_ctrl #(
    parameter logic [6:0] MAIN_ADDR = 7'h30,
    parameter int LOSS_CYC = rph_pkg::REF_LOSS_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire rph_pkg::rph_req_t req_i,
    input wire logic [rph_pkg::NUM_PORTS-1:0] lock_i,
    input wire logic reference_clock_input_i,
    output rph_pkg::rph_rsp_t rsp_o,
    output logic [rph_pkg::NUM_PORTS-1:0] port_on_o,
    output logic [rph_pkg::NUM_PORTS-1:0] fwd_on_o,
    output logic [rph_pkg::NUM_PORTS-1:0] eq_restart_o,
    output logic [rph_pkg::NUM_PORTS-1:0] eq_locked_o,
    output logic ref_internal_o,
    output logic ref_lost_o
);
    import rph_pkg::*;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic is_eq_cfg(input logic [7:0] off);
        return (off >= OFF_EQ_FIRST) && (off < OFF_EQ_STAT);
    endfunction

    function automatic logic is_dir(input logic [7:0] off);
        return (off >= OFF_DIR_FIRST) && (off <= OFF_DIR_LAST);
    endfunction

    logic [NUM_PORTS-1:0] port_en_r;
    logic [NUM_PORTS-1:0] fwd_r;
    logic [PW-1:0] page_r;
    logic [7:0] dir_r [NUM_PORTS];
    rph_eq_state_t eq_st_r [NUM_PORTS];

    logic dir_hit;
    logic [PW-1:0] dir_port;
    logic main_hit;
    logic acc;
    logic wr;
    logic [PW-1:0] sel_port;

    // ----------------------------------------
    // address match: main address or a per-port direct address
    // ----------------------------------------
    always_comb begin
        dir_hit = 1'b0;
        dir_port = '0;
        for (int p = NUM_PORTS - 1; p >= 0; p--) begin
            if (dir_r[p][0] && req_i.dev_addr == dir_r[p][7:1]) begin
                dir_hit = 1'b1;
                dir_port = PW'(p);
            end
        end
    end

    assign main_hit = (req_i.dev_addr == MAIN_ADDR);
    assign acc = req_i.valid && (main_hit || dir_hit);
    assign wr = acc && req_i.wr;
    // a direct address wins over the page pointer
    assign sel_port = dir_hit ? dir_port : page_r;

    // ----------------------------------------
    // shared registers
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            port_en_r <= RST_PORT_EN;
        end else if (wr && !req_i.remote && req_i.offset == OFF_PORT_EN) begin
            port_en_r <= req_i.wdata[NUM_PORTS-1:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fwd_r <= RST_FWD;
        end else if (wr && req_i.offset == OFF_FWD) begin
            fwd_r <= req_i.wdata[NUM_PORTS-1:0];
        end
    end

    // the direct paths have a fixed page of their own, so only the main path moves it
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            page_r <= RST_PAGE;
        end else if (wr && !dir_hit && req_i.offset == OFF_PAGE) begin
            page_r <= req_i.wdata[PW-1:0];
        end
    end

    // ----------------------------------------
    // per-port logic
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_port
            always_ff @(posedge ref_clk_i) begin
                if (rst_i) begin
                    dir_r[g] <= RST_DIR;
                end else if (wr && req_i.offset == OFF_DIR_FIRST + 8'(g)) begin
                    dir_r[g] <= req_i.wdata;
                end
            end

            // equalizer lock tracking; a disabled port sits in acquire
            always_ff @(posedge ref_clk_i) begin
                if (rst_i || !port_en_r[g]) begin
                    eq_st_r[g] <= EQ_ACQUIRE;
                end else begin
                    unique case (eq_st_r[g])
                        EQ_ACQUIRE: begin
                            if (lock_i[g]) begin
                                eq_st_r[g] <= EQ_LOCKED;
                            end
                        end
                        EQ_LOCKED: begin
                            if (!lock_i[g]) begin
                                eq_st_r[g] <= EQ_RESET;
                            end
                        end
                        EQ_RESET: begin
                            eq_st_r[g] <= EQ_ACQUIRE;
                        end
                        default: begin
                            eq_st_r[g] <= EQ_ACQUIRE;
                        end
                    endcase
                end
            end

            always_ff @(posedge ref_clk_i) begin
                if (rst_i) begin
                    eq_restart_o[g] <= 1'b0;
                    eq_locked_o[g] <= 1'b0;
                end else begin
                    eq_restart_o[g] <= port_en_r[g] && eq_st_r[g] == EQ_LOCKED
                        && !lock_i[g];
                    eq_locked_o[g] <= port_en_r[g] && lock_i[g]
                        && eq_st_r[g] != EQ_RESET;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            port_on_o <= '0;
            fwd_on_o <= '0;
        end else begin
            port_on_o <= port_en_r;
            fwd_on_o <= fwd_r & port_en_r;
        end
    end

    // ----------------------------------------
    // per-port equalizer registers
    // ----------------------------------------
    logic [7:0] mem_rdata;
    logic [1:0] eq_idx;

    assign eq_idx = 2'(req_i.offset - OFF_EQ_FIRST);

    rph_port_mem #(
        .DW(8),
        .AW(PW + 2)
    ) u_mem (
        .ref_clk_i(ref_clk_i),
        .we_i(wr && is_eq_cfg(req_i.offset)),
        .waddr_i({sel_port, eq_idx}),
        .wdata_i(req_i.wdata),
        .raddr_i({sel_port, eq_idx}),
        .rdata_o(mem_rdata)
    );

    // ----------------------------------------
    // read pipeline: answer two edges after the request
    // ----------------------------------------
    logic rd_pend_r;
    logic rd_ack_r;
    logic rd_dir_r;
    logic rd_wr_r;
    logic [PW-1:0] rd_port_r;
    logic [7:0] rd_off_r;
    logic [7:0] rd_wdata_r;
    logic [7:0] rdata;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_pend_r <= 1'b0;
            rd_ack_r <= 1'b0;
            rd_dir_r <= 1'b0;
            rd_wr_r <= 1'b0;
            rd_port_r <= '0;
            rd_off_r <= '0;
            rd_wdata_r <= '0;
        end else begin
            rd_pend_r <= req_i.valid;
            rd_ack_r <= acc;
            rd_dir_r <= dir_hit;
            rd_wr_r <= req_i.wr;
            rd_port_r <= sel_port;
            rd_off_r <= req_i.offset;
            rd_wdata_r <= req_i.wdata;
        end
    end

    always_comb begin
        rdata = 8'h00;
        if (rd_off_r == OFF_PORT_EN) begin
            rdata = 8'(port_en_r);
        end else if (rd_off_r == OFF_FWD) begin
            rdata = 8'(fwd_r);
        end else if (rd_off_r == OFF_PAGE) begin
            // main path shows the pointer after this request's own write
            rdata = rd_dir_r ? 8'(rd_port_r) : 8'(page_r);
        end else if (is_dir(rd_off_r)) begin
            rdata = dir_r[rd_off_r[PW-1:0]];
        end else if (is_eq_cfg(rd_off_r)) begin
            // storage reads before it writes, so a write answers with its own data
            rdata = rd_wr_r ? rd_wdata_r : mem_rdata;
        end else if (rd_off_r == OFF_EQ_STAT) begin
            rdata = {6'h00, eq_st_r[rd_port_r] == EQ_RESET,
                eq_st_r[rd_port_r] == EQ_LOCKED};
        end
    end

    // nacked requests return zero data
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o.done <= rd_pend_r;
            rsp_o.ack <= rd_pend_r && rd_ack_r;
            rsp_o.rdata <= (rd_pend_r && rd_ack_r) ? rdata : 8'h00;
        end
    end

    // ----------------------------------------
    // reference clock watch and source choice
    // ----------------------------------------
    logic ref_prev_r;
    logic [12:0] quiet_r;
    logic [4:0] good_r;
    logic ref_edge;
    logic quiet_over;

    assign ref_edge = ref_prev_r ^ reference_clock_input_i;
    // the count holds once past the limit, so a paused clock stays flagged
    assign quiet_over = quiet_r > 13'(LOSS_CYC);

    // the previous sample follows the pin through reset, so release shows no false edge
    always_ff @(posedge ref_clk_i) begin
        ref_prev_r <= reference_clock_input_i;
        if (rst_i) begin
            quiet_r <= '0;
        end else if (ref_edge) begin
            quiet_r <= '0;
        end else if (!quiet_over) begin
            quiet_r <= quiet_r + 13'd1;
        end
    end

    // hop to the external reference only after a run of clean edges
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            good_r <= '0;
            ref_internal_o <= 1'b1;
            ref_lost_o <= 1'b0;
        end else begin
            ref_lost_o <= quiet_over;
            if (quiet_over) begin
                good_r <= '0;
                ref_internal_o <= 1'b1;
            end else if (ref_edge && good_r != 5'(REF_GOOD_EDGES)) begin
                good_r <= good_r + 5'd1;
            end else if (good_r == 5'(REF_GOOD_EDGES)) begin
                ref_internal_o <= 1'b0;
            end
        end
    end
endmodule
